// ---- rtl/aoe_pkg.sv ----
// Function
// - correct gyro scale factor and/or bias using own acceleration measurement
// - optional one-pole low-pass filter on acceleration ahead of compensation; else raw
// - filter corner selectable: 0.001 Hz, 0.01 Hz, 0.1 Hz, 5 Hz
// - output word is 24-bit two's complement, sent high, middle, low byte
// - acceleration mode LSB is 2^-21/-20/-19/-18/-16 g for 2/5/10/30/80 g
// - 10 g acceleration: bit 23 weighs -2^4 g, bit 0 weighs 2^-19 g
// - velocity mode LSB is 2^-24/-23/-22/-21/-19 m/s per range
// - velocity sums window samples times 1/2000 s times standard gravity
// - average mode outputs mean of samples since previous transmission
package aoe_pkg;
    localparam int ACC_W = 32;
    localparam int WORD_W = 24;
    localparam int SUM_W = 48;
    localparam int CNT_W = 16;
    localparam int COEF_W = 16;
    localparam int WIDE_W = 81;
    localparam int AW = 8;
    localparam int DW = 32;

    localparam logic [AW-1:0] REG_CFG = 8'h00;
    localparam logic [AW-1:0] REG_COEF_SCALE = 8'h04;
    localparam logic [AW-1:0] REG_COEF_BIAS = 8'h08;
    localparam logic [AW-1:0] REG_LAST_WORD = 8'h0C;
    localparam logic [AW-1:0] REG_WIN_COUNT = 8'h10;

    localparam int CFG_RANGE_LSB = 0;
    localparam int CFG_UNIT_LSB = 3;
    localparam int CFG_LPF_EN_BIT = 5;
    localparam int CFG_CORNER_LSB = 6;
    localparam int CFG_SCALE_EN_BIT = 8;
    localparam int CFG_BIAS_EN_BIT = 9;

    typedef enum logic [2:0] {
        AOE_RNG_2G = 3'b000,
        AOE_RNG_5G = 3'b001,
        AOE_RNG_10G = 3'b010,
        AOE_RNG_30G = 3'b011,
        AOE_RNG_80G = 3'b100
    } aoe_range_t;

    typedef enum logic [1:0] {
        AOE_UNIT_ACCEL = 2'b00,
        AOE_UNIT_VELINC = 2'b01,
        AOE_UNIT_AVERAGE = 2'b10,
        AOE_UNIT_SPARE = 2'b11
    } aoe_unit_t;

    typedef enum logic [1:0] {
        AOE_FC_0HZ001 = 2'b00,
        AOE_FC_0HZ01 = 2'b01,
        AOE_FC_0HZ1 = 2'b10,
        AOE_FC_5HZ = 2'b11
    } aoe_corner_t;

    localparam aoe_range_t RST_RANGE = AOE_RNG_10G;
    localparam aoe_unit_t RST_UNIT = AOE_UNIT_ACCEL;
    localparam aoe_corner_t RST_CORNER = AOE_FC_5HZ;
    localparam logic [COEF_W-1:0] RST_COEF = 16'h0000;

    // input sample LSB is 2^-21 g; shift down to the range's LSB
    localparam logic [2:0] ACC_SH_2G = 3'h0;
    localparam logic [2:0] ACC_SH_5G = 3'h1;
    localparam logic [2:0] ACC_SH_10G = 3'h2;
    localparam logic [2:0] ACC_SH_30G = 3'h3;
    localparam logic [2:0] ACC_SH_80G = 3'h5;
    localparam int ACC_IN_FRAC = 21;

    // velocity: sum * (9.80665 / 2000) * 2^32, then shift per range
    localparam int SAMPLE_RATE_HZ = 2000;
    localparam int VEL_K_FRAC = 32;
    localparam logic signed [32:0] VEL_K = 33'sh01415825;
    localparam int VEL_SH_BASE = VEL_K_FRAC + ACC_IN_FRAC - 24;

    // one-pole step shift, 2000 Hz update, alpha ~ 2*pi*fc/fs
    localparam logic [4:0] LPF_SH_0HZ001 = 5'h12;
    localparam logic [4:0] LPF_SH_0HZ01 = 5'h0F;
    localparam logic [4:0] LPF_SH_0HZ1 = 5'h0C;
    localparam logic [4:0] LPF_SH_5HZ = 5'h06;
    localparam int LPF_FRAC = 20;

    // bias coef: gyro LSB per g; scale coef: Q15 per g
    localparam int COMP_BIAS_SH = ACC_IN_FRAC;
    localparam int COMP_SCALE_SH = ACC_IN_FRAC + 15;

    function automatic logic [WORD_W-1:0] aoe_sat24(input logic signed [WIDE_W-1:0] v);
        if (v > 81'sh7FFFFF) begin
            return 24'h7FFFFF;
        end else if (v < -81'sh800000) begin
            return 24'h800000;
        end
        return v[WORD_W-1:0];
    endfunction : aoe_sat24
endpackage : aoe_pkg

// ---- rtl/aoe_lpf.sv ----
`timescale 1ns/1ps
module aoe_lpf
    import aoe_pkg::*;
(
    input wire logic i_clk,                     // system clock
    input wire logic i_nrst,                    // async reset, active low
    input wire logic i_vld,                     // new sample
    input wire logic i_en,                      // filter switched in
    input wire logic [4:0] i_shift,             // step shift from corner
    input wire logic signed [ACC_W-1:0] i_x,    // raw sample
    output logic signed [ACC_W-1:0] o_y         // filtered sample
);
    logic signed [ACC_W+LPF_FRAC-1:0] state;
    logic signed [ACC_W+LPF_FRAC:0] diff;
    logic signed [ACC_W+LPF_FRAC-1:0] x_ext;

    assign x_ext = {i_x, {LPF_FRAC{1'b0}}};
    assign diff = {x_ext[ACC_W+LPF_FRAC-1], x_ext} - {state[ACC_W+LPF_FRAC-1], state};
    assign o_y = state[ACC_W+LPF_FRAC-1:LPF_FRAC];

    // bypassed filter tracks input so switching in has no transient
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= '0;
        end else if (i_vld && !i_en) begin
            state <= x_ext;
        end else if (i_vld) begin
            state <= state + (ACC_W+LPF_FRAC)'(diff >>> i_shift);
        end
    end

    chk_lpf_bypass_track: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_vld && !i_en) |=> (o_y == $past(i_x)))
        else $error("bypassed filter does not follow input");
endmodule : aoe_lpf

// ---- rtl/aoe_accel_fmt.sv ----
`timescale 1ns/1ps
module aoe_accel_fmt
    import aoe_pkg::*;
(
    input wire logic i_clk,                      // system clock, 10 MHz
    input wire logic i_nrst,                     // async reset, active low
    input wire logic [AW-1:0] i_addr,            // register byte address
    input wire logic [DW-1:0] i_wdata,           // register write data
    input wire logic i_wr,                       // write strobe
    input wire logic i_rd,                       // read strobe
    output logic [DW-1:0] o_rdata,               // read data, cycle after i_rd
    input wire logic i_smp_vld,                  // internal 2000 Hz sample strobe
    input wire logic signed [ACC_W-1:0] i_smp,   // acceleration, LSB 2^-21 g
    input wire logic i_tx,                       // transmission instant
    output logic o_word_vld,                     // output bytes updated
    output logic [7:0] o_accel_byte_high,        // acceleration/average MSB
    output logic [7:0] o_accel_byte_mid,         // acceleration/average mid
    output logic [7:0] o_accel_byte_low,         // acceleration/average LSB
    output logic [7:0] o_velinc_byte_high,       // velocity increment MSB
    output logic [7:0] o_velinc_byte_mid,        // velocity increment mid
    output logic [7:0] o_velinc_byte_low,        // velocity increment LSB
    input wire logic i_gyro_vld,                 // gyro sample strobe
    input wire logic signed [WORD_W-1:0] i_gyro, // gyro sample
    output logic o_gyro_vld,                     // compensated gyro valid
    output logic [WORD_W-1:0] o_gyro             // compensated gyro sample
);
    aoe_range_t range;
    aoe_unit_t unit;
    aoe_corner_t corner;
    logic lpf_en;
    logic scale_en;
    logic bias_en;
    logic signed [COEF_W-1:0] coef_scale;
    logic signed [COEF_W-1:0] coef_bias;

    logic signed [ACC_W-1:0] latest;
    logic signed [SUM_W-1:0] win_sum;
    logic [CNT_W-1:0] win_cnt;
    logic [WORD_W-1:0] last_word;

    logic [2:0] acc_sh;
    logic [4:0] lpf_sh;
    logic signed [ACC_W-1:0] acc_filt;
    logic signed [ACC_W-1:0] acc_used;
    logic signed [SUM_W-1:0] avg;
    logic signed [WIDE_W-1:0] vel_prod;
    logic [WORD_W-1:0] next_word;
    logic signed [WIDE_W-1:0] corr_scale;
    logic signed [WIDE_W-1:0] corr_bias;
    logic signed [WIDE_W-1:0] next_gyro_wide;

    // configuration writes
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            range <= RST_RANGE;
            unit <= RST_UNIT;
            corner <= RST_CORNER;
            lpf_en <= 1'b0;
            scale_en <= 1'b0;
            bias_en <= 1'b0;
        end else if (i_wr && i_addr == REG_CFG) begin
            range <= aoe_range_t'(i_wdata[CFG_RANGE_LSB +: 3]);
            unit <= aoe_unit_t'(i_wdata[CFG_UNIT_LSB +: 2]);
            corner <= aoe_corner_t'(i_wdata[CFG_CORNER_LSB +: 2]);
            lpf_en <= i_wdata[CFG_LPF_EN_BIT];
            scale_en <= i_wdata[CFG_SCALE_EN_BIT];
            bias_en <= i_wdata[CFG_BIAS_EN_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            coef_scale <= RST_COEF;
            coef_bias <= RST_COEF;
        end else if (i_wr) begin
            if (i_addr == REG_COEF_SCALE) begin
                coef_scale <= i_wdata[COEF_W-1:0];
            end
            if (i_addr == REG_COEF_BIAS) begin
                coef_bias <= i_wdata[COEF_W-1:0];
            end
        end
    end

    // register reads; unmapped and idle cycles give zero
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= '0;
        end else if (!i_rd) begin
            o_rdata <= '0;
        end else begin
            unique case (i_addr)
                REG_CFG: o_rdata <= DW'({bias_en, scale_en, corner, lpf_en, unit, range});
                REG_COEF_SCALE: o_rdata <= DW'(coef_scale);
                REG_COEF_BIAS: o_rdata <= DW'(coef_bias);
                REG_LAST_WORD: o_rdata <= DW'(last_word);
                REG_WIN_COUNT: o_rdata <= DW'(win_cnt);
                default: o_rdata <= '0;
            endcase
        end
    end

    // range selects the scaling shift; unused codes fall back to 10 g
    always_comb begin
        unique case (range)
            AOE_RNG_2G: acc_sh = ACC_SH_2G;
            AOE_RNG_5G: acc_sh = ACC_SH_5G;
            AOE_RNG_10G: acc_sh = ACC_SH_10G;
            AOE_RNG_30G: acc_sh = ACC_SH_30G;
            AOE_RNG_80G: acc_sh = ACC_SH_80G;
            default: acc_sh = ACC_SH_10G;
        endcase
    end

    always_comb begin
        unique case (corner)
            AOE_FC_0HZ001: lpf_sh = LPF_SH_0HZ001;
            AOE_FC_0HZ01: lpf_sh = LPF_SH_0HZ01;
            AOE_FC_0HZ1: lpf_sh = LPF_SH_0HZ1;
            AOE_FC_5HZ: lpf_sh = LPF_SH_5HZ;
        endcase
    end

    // sample window since previous transmission
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            latest <= '0;
            win_sum <= '0;
            win_cnt <= '0;
        end else begin
            if (i_smp_vld) begin
                latest <= i_smp;
            end
            if (i_tx) begin
                win_sum <= i_smp_vld ? SUM_W'(i_smp) : '0;
                win_cnt <= i_smp_vld ? CNT_W'(1) : '0;
            end else if (i_smp_vld) begin
                win_sum <= win_sum + SUM_W'(i_smp);
                if (win_cnt != '1) begin
                    win_cnt <= win_cnt + CNT_W'(1);
                end
            end
        end
    end

    assign avg = (win_cnt == '0) ? SUM_W'(latest) : win_sum / $signed({1'b0, win_cnt});
    // widen before multiplying so the product cannot wrap
    assign vel_prod = WIDE_W'(win_sum) * WIDE_W'(VEL_K);

    always_comb begin
        unique case (unit)
            AOE_UNIT_VELINC: next_word = aoe_sat24(vel_prod >>> (VEL_SH_BASE + acc_sh));
            AOE_UNIT_AVERAGE: next_word = aoe_sat24(WIDE_W'(avg) >>> acc_sh);
            default: next_word = aoe_sat24(WIDE_W'(latest) >>> acc_sh);
        endcase
    end

    // output word, split high byte first
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            last_word <= '0;
            o_word_vld <= 1'b0;
            o_accel_byte_high <= '0;
            o_accel_byte_mid <= '0;
            o_accel_byte_low <= '0;
            o_velinc_byte_high <= '0;
            o_velinc_byte_mid <= '0;
            o_velinc_byte_low <= '0;
        end else begin
            o_word_vld <= i_tx;
            if (i_tx) begin
                last_word <= next_word;
                if (unit == AOE_UNIT_VELINC) begin
                    o_velinc_byte_high <= next_word[23:16];
                    o_velinc_byte_mid <= next_word[15:8];
                    o_velinc_byte_low <= next_word[7:0];
                end else begin
                    o_accel_byte_high <= next_word[23:16];
                    o_accel_byte_mid <= next_word[15:8];
                    o_accel_byte_low <= next_word[7:0];
                end
            end
        end
    end

    aoe_lpf u_lpf (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_vld(i_smp_vld),
        .i_en(lpf_en),
        .i_shift(lpf_sh),
        .i_x(i_smp),
        .o_y(acc_filt)
    );

    assign acc_used = lpf_en ? acc_filt : latest;

    // gyro g-compensation
    assign corr_scale = scale_en
        ? WIDE_W'((WIDE_W'(i_gyro) * WIDE_W'(acc_used) * WIDE_W'(coef_scale)) >>> COMP_SCALE_SH)
        : '0;
    assign corr_bias = bias_en
        ? WIDE_W'((WIDE_W'(acc_used) * WIDE_W'(coef_bias)) >>> COMP_BIAS_SH)
        : '0;
    assign next_gyro_wide = WIDE_W'(i_gyro) - corr_scale - corr_bias;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_gyro <= '0;
            o_gyro_vld <= 1'b0;
        end else begin
            o_gyro_vld <= i_gyro_vld;
            if (i_gyro_vld) begin
                o_gyro <= aoe_sat24(next_gyro_wide);
            end
        end
    end

    chk_bytes_split_order: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_tx && unit == AOE_UNIT_ACCEL) |=>
        ({o_accel_byte_high, o_accel_byte_mid, o_accel_byte_low} == last_word))
        else $error("accel bytes do not match word");

    chk_accel_10g_scale: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_tx && unit == AOE_UNIT_ACCEL && range == AOE_RNG_10G
         && latest < 32'sh01000000 && latest > -32'sh01000000)
        |=> (last_word == 24'($past(latest) >>> 2)))
        else $error("10 g word not latest sample over four");

    chk_accel_2g_scale: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_tx && unit == AOE_UNIT_ACCEL && range == AOE_RNG_2G && latest > 32'sh007FFFFF)
        |=> (last_word == 24'h7FFFFF))
        else $error("2 g word not saturated");

    chk_velinc_zero_sum: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_tx && unit == AOE_UNIT_VELINC && win_sum == '0)
        |=> (o_word_vld && {o_velinc_byte_high, o_velinc_byte_mid, o_velinc_byte_low} == 24'h0))
        else $error("empty window gave nonzero velocity");

    chk_window_restart: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_tx && !i_smp_vld) |=> (win_sum == '0 && win_cnt == '0))
        else $error("window not cleared on transmission");

    chk_window_count_step: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_smp_vld && !i_tx && win_cnt != '1) |=> (win_cnt == $past(win_cnt) + CNT_W'(1)))
        else $error("window count not advanced by sample");

    chk_comp_off_pass: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_gyro_vld && !scale_en && !bias_en) |=> (o_gyro_vld && o_gyro == $past(i_gyro)))
        else $error("uncompensated gyro altered");

    chk_filter_select: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_smp_vld && !lpf_en) |=> (acc_used == $past(i_smp)))
        else $error("unfiltered path not used when filter off");

    chk_cfg_held: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_wr && i_addr == REG_CFG && i_wdata[2:0] == 3'h4 && i_wdata[4:3] == 2'h1)
        |=> (range == AOE_RNG_80G && unit == AOE_UNIT_VELINC)
        ##1 (($past(i_wr) && $past(i_addr) == REG_CFG)
             || (range == AOE_RNG_80G && unit == AOE_UNIT_VELINC)))
        else $error("range or unit not held after write");
endmodule : aoe_accel_fmt

// ---- verif/aoe_host_model.sv ----
`timescale 1ns/1ps
module aoe_host_model (
    input wire logic i_clk,                    // system clock
    input wire logic i_nrst,                   // async reset, active low
    input wire logic i_word_vld,               // output words updated
    input wire logic [7:0] i_accel_byte_high,  // accel msb
    input wire logic [7:0] i_accel_byte_mid,   // accel mid
    input wire logic [7:0] i_accel_byte_low,   // accel lsb
    input wire logic [7:0] i_velinc_byte_high, // velocity msb
    input wire logic [7:0] i_velinc_byte_mid,  // velocity mid
    input wire logic [7:0] i_velinc_byte_low,  // velocity lsb
    output logic [23:0] o_accel_word,          // last accel word received
    output logic [23:0] o_velinc_word          // last velocity word received
);
    // rebuild words from msb-first byte triplets
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_accel_word <= 24'h000000;
            o_velinc_word <= 24'h000000;
        end else if (i_word_vld) begin
            o_accel_word <= {i_accel_byte_high, i_accel_byte_mid, i_accel_byte_low};
            o_velinc_word <= {i_velinc_byte_high, i_velinc_byte_mid, i_velinc_byte_low};
        end
    end
endmodule : aoe_host_model

// ---- verif/aoe_accel_fmt_bench.sv ----
`timescale 1ns/1ps
module aoe_accel_fmt_bench;
    import aoe_pkg::*;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [AW-1:0] i_addr = '0;
    logic [DW-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_smp_vld = 1'b0;
    logic signed [ACC_W-1:0] i_smp = '0;
    logic i_tx = 1'b0;
    logic i_gyro_vld = 1'b0;
    logic signed [WORD_W-1:0] i_gyro = '0;
    logic [DW-1:0] o_rdata;
    logic o_word_vld;
    logic o_gyro_vld;
    logic [WORD_W-1:0] o_gyro;
    logic [7:0] ah, am, al, vh, vm, vl;
    logic [23:0] acc_w, vel_w;
    logic [DW-1:0] rv;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    always #50 i_clk = ~i_clk;

    aoe_accel_fmt dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_smp_vld(i_smp_vld), .i_smp(i_smp),
        .i_tx(i_tx), .o_word_vld(o_word_vld), .o_accel_byte_high(ah), .o_accel_byte_mid(am),
        .o_accel_byte_low(al), .o_velinc_byte_high(vh), .o_velinc_byte_mid(vm),
        .o_velinc_byte_low(vl), .i_gyro_vld(i_gyro_vld), .i_gyro(i_gyro),
        .o_gyro_vld(o_gyro_vld), .o_gyro(o_gyro));

    aoe_host_model host (.i_clk(i_clk), .i_nrst(i_nrst), .i_word_vld(o_word_vld),
        .i_accel_byte_high(ah), .i_accel_byte_mid(am), .i_accel_byte_low(al),
        .i_velinc_byte_high(vh), .i_velinc_byte_mid(vm), .i_velinc_byte_low(vl),
        .o_accel_word(acc_w), .o_velinc_word(vel_w));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    function automatic logic [23:0] sat(input longint v);
        if (v > 64'sh7FFFFF) begin
            return 24'h7FFFFF;
        end
        if (v < -64'sh800000) begin
            return 24'h800000;
        end
        return v[23:0];
    endfunction : sat

    function automatic int rsh(input int r);
        return (r == 4) ? 5 : r;
    endfunction : rsh

    function automatic logic [31:0] cfg(input int r, u, f, c, se, be);
        return (r << CFG_RANGE_LSB) | (u << CFG_UNIT_LSB) | (f << CFG_LPF_EN_BIT)
            | (c << CFG_CORNER_LSB) | (se << CFG_SCALE_EN_BIT) | (be << CFG_BIAS_EN_BIT);
    endfunction : cfg

    task automatic reg_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [AW-1:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        rv = o_rdata;
    endtask : reg_rd

    task automatic smp(input longint x);
        @(posedge i_clk);
        i_smp_vld <= 1'b1;
        i_smp <= x[31:0];
        @(posedge i_clk);
        i_smp_vld <= 1'b0;
        i_smp <= ~x[31:0];
    endtask : smp

    task automatic tx();
        @(posedge i_clk);
        i_tx <= 1'b1;
        @(posedge i_clk);
        i_tx <= 1'b0;
        #1;
        check(o_word_vld, 1'b1, "word strobe");
        @(posedge i_clk);
        #1;
        check(o_word_vld, 1'b0, "word strobe ends");
    endtask : tx

    task automatic gyro(input longint g, input longint e);
        @(posedge i_clk);
        i_gyro_vld <= 1'b1;
        i_gyro <= g[23:0];
        @(posedge i_clk);
        i_gyro_vld <= 1'b0;
        i_gyro <= ~g[23:0];
        #1;
        check(o_gyro_vld, 1'b1, "gyro strobe");
        check(o_gyro, sat(e), "gyro value");
    endtask : gyro

    task automatic t_regs();
        reg_rd(REG_CFG);
        check(rv, 32'h000000C2, "reset cfg");
        reg_wr(REG_CFG, cfg(4, 1, 1, 1, 1, 1));
        reg_rd(REG_CFG);
        check(rv, 32'h0000036C, "cfg readback");
        reg_rd(8'h14);
        check(rv, 32'h00000000, "unmapped read");
    endtask : t_regs

    task automatic t_accel();
        longint xs[3] = '{-64'sh2DC6C0, 64'sh1000000, 64'sh200000};
        logic [23:0] e;
        for (int r = 0; r < 5; r++) begin
            for (int i = 0; i < 3; i++) begin
                reg_wr(REG_CFG, cfg(r, 0, 0, 3, 0, 0));
                smp(xs[i]);
                tx();
                e = sat(xs[i] >>> rsh(r));
                check(acc_w, e, "accel word");
                check(ah, e[23:16], "accel high byte");
            end
        end
    endtask : t_accel

    task automatic t_vel();
        longint xs[4] = '{64'sh200000, 64'sh200A00, -64'sh7A120, 64'sh1E847F};
        longint sum;
        logic [23:0] held;
        logic [23:0] e;
        for (int r = 0; r < 5; r++) begin
            reg_wr(REG_CFG, cfg(r, 1, 0, 3, 0, 0));
            tx();
            held = acc_w;
            sum = 0;
            foreach (xs[i]) begin
                smp(xs[i]);
                sum += xs[i];
            end
            reg_rd(REG_WIN_COUNT);
            check(rv[15:0], 16'h0004, "window count");
            tx();
            e = sat((sum * 64'sh1415825) >>> (29 + rsh(r)));
            check(vel_w, e, "velocity word");
            check(acc_w, held, "accel word held");
        end
    endtask : t_vel

    task automatic t_avg();
        longint xs[4] = '{-64'shF4243, -64'sh1E8480, 64'sh5, 64'sh1};
        longint sum = 0;
        reg_wr(REG_CFG, cfg(2, 2, 0, 3, 0, 0));
        tx();
        foreach (xs[i]) begin
            smp(xs[i]);
            sum += xs[i];
        end
        tx();
        check(acc_w, sat((sum / 4) >>> 2), "average word");
        // spare unit and unused range code fall back to 10 g acceleration
        reg_wr(REG_CFG, cfg(7, 3, 0, 3, 0, 0));
        smp(64'sh400);
        tx();
        check(acc_w, 24'h000100, "spare unit word");
        reg_rd(REG_LAST_WORD);
        check(rv, 32'h00000100, "last word register");
    endtask : t_avg

    task automatic t_gyro();
        longint x = 64'sh40000000;
        longint a;
        int ks[4] = '{18, 15, 12, 6};
        reg_wr(REG_COEF_SCALE, 32'h00004000);
        reg_wr(REG_COEF_BIAS, 32'h00007FFF);
        reg_rd(REG_COEF_BIAS);
        check(rv[15:0], 16'h7FFF, "bias coef");
        reg_wr(REG_CFG, cfg(2, 0, 0, 3, 1, 0));
        smp(64'sh200000);
        gyro(64'sh1000, 64'sh1000 - ((64'sh1000 * 64'sh200000 * 64'sh4000) >>> 36));
        // index 4 leaves the filter bypassed
        for (int i = 0; i < 5; i++) begin
            reg_wr(REG_CFG, cfg(2, 0, 0, 3, 0, 1));
            smp(0);
            reg_wr(REG_CFG, cfg(2, 0, (i < 4), i % 4, 0, 1));
            smp(x);
            a = (i < 4) ? (x >>> ks[i % 4]) : x;
            gyro(0, -((a * 64'sh7FFF) >>> 21));
        end
    endtask : t_gyro

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_regs();
        t_accel();
        t_vel();
        t_avg();
        t_gyro();
        complete_run();
    end
endmodule : aoe_accel_fmt_bench
